// ==== hdl/bis_pkg.sv ====
// constants, timing figures, fault codes and state encoding of the burner ignition sequencer
package bis_pkg;

  // time base
  localparam int CLK_MHZ = 125;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  localparam int TMR_W = 16;

  // phase lengths in seconds
  localparam int PREIGN_S = 3;
  localparam int WIN_LONG_S = 5;
  localparam int WIN_SHORT_S = 3;
  localparam int SETTLE_S = 5;
  localparam int TRIAL_LONG_S = 5;
  localparam int TRIAL_SHORT_S = 3;
  localparam int REACT_SHORT_S = 1;
  localparam int REACT_LONG_S = 2;
  localparam int STAB_S = 5;
  localparam int TEST_FLAMEOUT_S = 15;
  localparam int POSTRUN_S = 15;
  localparam int LINK_DETECT_S = 1;

  // configuration latch after main valve operating time
  localparam int LATCH_HOURS = 200;
  localparam int LATCH_TICKS = LATCH_HOURS * 3600 * TICKS_PER_S;
  localparam int HOUR_W = 24;

  // jumper bit positions, a set bit means the jumper is intact
  localparam int JMP_W = 3;
  localparam int JMP_WIN = 0;
  localparam int JMP_TRIAL = 1;
  localparam int JMP_AIR = 2;
  localparam logic [JMP_W-1:0] JMP_RESET = 3'h7;

  // fault codes
  localparam logic [7:0] FC_NONE = 8'h00;
  localparam logic [7:0] FC_NO_FLAME_WIN = 8'h01;
  localparam logic [7:0] FC_LOW_FIRE = 8'h02;
  localparam logic [7:0] FC_FLAME_LOSS = 8'h03;
  localparam logic [7:0] FC_AIR_LINK = 8'h04;
  localparam logic [7:0] FC_INTERLOCK = 8'h05;
  localparam logic [7:0] FC_JUMPER = 8'h6e;

  typedef enum logic [10:0] {
    ST_STANDBY = 11'h001,
    ST_PREIGN = 11'h002,
    ST_WINDOW = 11'h004,
    ST_SETTLE = 11'h008,
    ST_TRIAL = 11'h010,
    ST_STAB = 11'h020,
    ST_RUN = 11'h040,
    ST_POSTRUN = 11'h080,
    ST_LOCKOUT = 11'h100,
    ST_SPARE0 = 11'h200,
    ST_SPARE1 = 11'h400
  } bis_state_type;

  function automatic logic [TMR_W-1:0] to_ticks(input int secs);
    to_ticks = TMR_W'(secs * TICKS_PER_S);
  endfunction

endpackage

// ==== hdl/bis_jumper_guard.sv ====
// jumper sampling, main valve hour count, latch of the configuration and change detection
module bis_jumper_guard #(
  parameter int LATCH_TICKS = bis_pkg::LATCH_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // time base and activity
  input wire logic tick,
  input wire logic main_on,
  // jumpers
  input wire logic [bis_pkg::JMP_W-1:0] jumpers,
  output logic [bis_pkg::JMP_W-1:0] cfg_r,
  output logic changed_r
);

  logic sampled_r;
  logic latched_r;
  logic [bis_pkg::HOUR_W-1:0] hours_r;
  logic [bis_pkg::JMP_W-1:0] stored_r;
  wire hours_full = hours_r >= bis_pkg::HOUR_W'(LATCH_TICKS);

  // the stored copy stands in for non-volatile memory; it is lost on reset here
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sampled_r <= 1'b0;
      latched_r <= 1'b0;
      hours_r <= '0;
      cfg_r <= bis_pkg::JMP_RESET;
      stored_r <= bis_pkg::JMP_RESET;
      changed_r <= 1'b0;
    end else if (clk_en) begin
      if (!sampled_r) begin
        sampled_r <= 1'b1;
        cfg_r <= jumpers;
      end
      if (tick && main_on && !hours_full)
        hours_r <= hours_r + 1'b1;
      if (hours_full && !latched_r) begin
        latched_r <= 1'b1;
        stored_r <= cfg_r;
      end
      if (latched_r && jumpers != stored_r)
        changed_r <= 1'b1;
    end
  end

endmodule // bis_jumper_guard

// ==== hdl/bis_sequencer.sv ====
// ignition trial, run and post-run sequencer with lockout and jumper supervision
module bis_sequencer #(
  parameter int TICK_CYCLES = bis_pkg::TICK_CYCLES,
  parameter int LATCH_TICKS = bis_pkg::LATCH_TICKS,
  parameter int POSTRUN_S = bis_pkg::POSTRUN_S,
  parameter bit MODULATING = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // controls
  input wire logic call_heat,
  input wire logic test_mode,
  input wire logic lockout_reset,
  input wire logic react_long,
  input wire logic [bis_pkg::JMP_W-1:0] jumpers,
  // purge sequencer handshake
  input wire logic purge_drive_high,
  input wire logic purge_timing,
  input wire logic purge_drive_low,
  input wire logic purge_done,
  output logic purge_hold_r,
  output logic purge_freeze_r,
  // field inputs
  input wire logic flame,
  input wire logic low_fire_sw,
  input wire logic airflow_sw,
  input wire logic preign_interlock,
  // field outputs
  output logic ignition_r,
  output logic pilot_interrupted_r,
  output logic pilot_intermittent_r,
  output logic main_valve_r,
  output logic blower_r,
  output logic fire_low_r,
  output logic fire_high_r,
  output logic fire_modulate_r,
  // status
  output logic lockout_r,
  output logic [7:0] fault_code_r,
  output logic [10:0] state_r
);

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);

  bis_pkg::bis_state_type st_r, st_nxt;
  logic [PRE_W-1:0] pre_r;
  logic tick_r;
  logic [bis_pkg::TMR_W-1:0] phase_r;
  logic [bis_pkg::TMR_W-1:0] loss_r;
  logic [bis_pkg::TMR_W-1:0] link_r;
  logic permanent_r;
  logic [7:0] fault_nxt;
  logic [bis_pkg::JMP_W-1:0] cfg;
  logic jumper_changed;

  bis_jumper_guard #(
    .LATCH_TICKS(LATCH_TICKS)
  ) u_guard (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(tick_r),
    .main_on(main_valve_r),
    .jumpers(jumpers),
    .cfg_r(cfg),
    .changed_r(jumper_changed)
  );

  // decoded configuration
  wire [bis_pkg::TMR_W-1:0] win_len = cfg[bis_pkg::JMP_WIN] ?
    bis_pkg::to_ticks(bis_pkg::WIN_LONG_S) : bis_pkg::to_ticks(bis_pkg::WIN_SHORT_S);
  wire [bis_pkg::TMR_W-1:0] trial_len = cfg[bis_pkg::JMP_TRIAL] ?
    bis_pkg::to_ticks(bis_pkg::TRIAL_LONG_S) : bis_pkg::to_ticks(bis_pkg::TRIAL_SHORT_S);
  wire airflow_present = !cfg[bis_pkg::JMP_AIR];
  wire [bis_pkg::TMR_W-1:0] react_len = react_long ?
    bis_pkg::to_ticks(bis_pkg::REACT_LONG_S) : bis_pkg::to_ticks(bis_pkg::REACT_SHORT_S);

  // test honouring points: settle freezes, run only moves the motor
  wire settle_test = (st_r == bis_pkg::ST_SETTLE) && test_mode;
  wire phase_run = tick_r && !settle_test;
  wire loss_watch = (st_r == bis_pkg::ST_TRIAL) || (st_r == bis_pkg::ST_STAB) || (st_r == bis_pkg::ST_RUN) ||
    settle_test;
  wire [bis_pkg::TMR_W-1:0] loss_len = settle_test ? bis_pkg::to_ticks(bis_pkg::TEST_FLAMEOUT_S) : react_len;
  wire loss_trip = loss_watch && !flame && (loss_r >= loss_len);
  wire low_fire_open = MODULATING && !low_fire_sw;
  // the installer link shows as the airflow input following call-for-heat while the blower is off
  wire link_seen = (st_r == bis_pkg::ST_STANDBY) && airflow_present && call_heat && airflow_sw && !blower_r;
  wire link_trip = link_r >= bis_pkg::to_ticks(bis_pkg::LINK_DETECT_S);

  always_comb begin
    st_nxt = st_r;
    fault_nxt = fault_code_r;
    case (st_r)
      bis_pkg::ST_STANDBY: begin
        if (link_trip) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_AIR_LINK;
        end else if (purge_done && call_heat) begin
          st_nxt = bis_pkg::ST_PREIGN;
        end
      end
      bis_pkg::ST_PREIGN: begin
        // interlock is only watched here, from the window onward it is ignored
        if (!preign_interlock) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_INTERLOCK;
        end else if (phase_r >= bis_pkg::to_ticks(bis_pkg::PREIGN_S)) begin
          st_nxt = bis_pkg::ST_WINDOW;
        end
      end
      bis_pkg::ST_WINDOW: begin
        if (low_fire_open) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_LOW_FIRE;
        end else if (phase_r >= win_len) begin
          st_nxt = flame ? bis_pkg::ST_SETTLE : bis_pkg::ST_LOCKOUT;
          fault_nxt = flame ? fault_code_r : bis_pkg::FC_NO_FLAME_WIN;
        end
      end
      bis_pkg::ST_SETTLE: begin
        if (settle_test ? loss_trip : !flame) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_FLAME_LOSS;
        end else if (!test_mode && phase_r >= bis_pkg::to_ticks(bis_pkg::SETTLE_S)) begin
          st_nxt = bis_pkg::ST_TRIAL;
        end
      end
      bis_pkg::ST_TRIAL: begin
        if (low_fire_open) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_LOW_FIRE;
        end else if (loss_trip) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_FLAME_LOSS;
        end else if (phase_r >= trial_len) begin
          st_nxt = bis_pkg::ST_STAB;
        end
      end
      bis_pkg::ST_STAB: begin
        if (loss_trip) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_FLAME_LOSS;
        end else if (phase_r >= bis_pkg::to_ticks(bis_pkg::STAB_S)) begin
          st_nxt = bis_pkg::ST_RUN;
        end
      end
      bis_pkg::ST_RUN: begin
        if (loss_trip) begin
          st_nxt = bis_pkg::ST_LOCKOUT;
          fault_nxt = bis_pkg::FC_FLAME_LOSS;
        end else if (!call_heat) begin
          st_nxt = bis_pkg::ST_POSTRUN;
        end
      end
      bis_pkg::ST_POSTRUN: begin
        if (phase_r >= bis_pkg::to_ticks(POSTRUN_S))
          st_nxt = bis_pkg::ST_STANDBY;
      end
      bis_pkg::ST_LOCKOUT: begin
        if (lockout_reset && !permanent_r) begin
          st_nxt = bis_pkg::ST_STANDBY;
          fault_nxt = bis_pkg::FC_NONE;
        end
      end
      default: begin
        st_nxt = bis_pkg::ST_LOCKOUT;
      end
    endcase
    // a changed configuration overrides everything and only reset_n clears it, never lockout_reset
    if (jumper_changed) begin
      st_nxt = bis_pkg::ST_LOCKOUT;
      fault_nxt = bis_pkg::FC_JUMPER;
    end
  end

  // outputs derived from the next state so the registered pins change with it
  wire n_preign = st_nxt == bis_pkg::ST_PREIGN;
  wire n_window = st_nxt == bis_pkg::ST_WINDOW;
  wire n_settle = st_nxt == bis_pkg::ST_SETTLE;
  wire n_trial = st_nxt == bis_pkg::ST_TRIAL;
  wire n_stab = st_nxt == bis_pkg::ST_STAB;
  wire n_run = st_nxt == bis_pkg::ST_RUN;
  wire n_post = st_nxt == bis_pkg::ST_POSTRUN;
  wire n_standby = st_nxt == bis_pkg::ST_STANDBY;
  wire purge_any = n_standby && (purge_drive_high || purge_timing || purge_drive_low);
  wire ign_nxt = n_preign || n_window;
  wire pil_int_nxt = n_window || n_settle || n_trial;
  wire pil_itm_nxt = n_window || n_settle || n_trial || n_stab || n_run;
  wire main_nxt = n_trial || n_stab || n_run;
  wire blower_nxt = purge_any || n_preign || n_window || n_settle || n_trial || n_stab || n_run || n_post;
  wire mod_nxt = MODULATING && n_run && !test_mode;
  wire high_nxt = MODULATING && n_standby && (purge_drive_high || purge_timing);
  wire low_nxt = MODULATING && !mod_nxt && !high_nxt && (blower_nxt || n_post);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pre_r <= '0;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      // restart on each phase change, else a phase could end up to a tick short
      if (st_nxt != st_r) begin
        pre_r <= '0;
        tick_r <= 1'b0;
      end else begin
        tick_r <= pre_r == PRE_W'(TICK_CYCLES - 1);
        pre_r <= (pre_r == PRE_W'(TICK_CYCLES - 1)) ? '0 : pre_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_r <= '0;
      loss_r <= '0;
      link_r <= '0;
    end else if (clk_en) begin
      if (st_nxt != st_r)
        phase_r <= '0;
      else if (phase_run && phase_r != '1)
        phase_r <= phase_r + 1'b1;
      if (!loss_watch || flame || st_nxt != st_r)
        loss_r <= '0;
      else if (tick_r && loss_r != '1)
        loss_r <= loss_r + 1'b1;
      if (!link_seen)
        link_r <= '0;
      else if (tick_r && link_r != '1)
        link_r <= link_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r <= bis_pkg::ST_STANDBY;
      fault_code_r <= bis_pkg::FC_NONE;
      permanent_r <= 1'b0;
      lockout_r <= 1'b0;
      state_r <= bis_pkg::ST_STANDBY;
    end else if (clk_en) begin
      st_r <= st_nxt;
      state_r <= st_nxt;
      fault_code_r <= fault_nxt;
      lockout_r <= st_nxt == bis_pkg::ST_LOCKOUT;
      if (jumper_changed)
        permanent_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ignition_r <= 1'b0;
      pilot_interrupted_r <= 1'b0;
      pilot_intermittent_r <= 1'b0;
      main_valve_r <= 1'b0;
      blower_r <= 1'b0;
      fire_low_r <= 1'b0;
      fire_high_r <= 1'b0;
      fire_modulate_r <= 1'b0;
      purge_hold_r <= 1'b0;
      purge_freeze_r <= 1'b0;
    end else if (clk_en) begin
      ignition_r <= ign_nxt;
      pilot_interrupted_r <= pil_int_nxt;
      pilot_intermittent_r <= pil_itm_nxt;
      main_valve_r <= main_nxt;
      blower_r <= blower_nxt;
      fire_low_r <= low_nxt;
      fire_high_r <= high_nxt;
      fire_modulate_r <= mod_nxt;
      purge_hold_r <= test_mode && n_standby && (purge_drive_high || purge_drive_low);
      purge_freeze_r <= test_mode && n_standby && purge_timing;
    end
  end

endmodule // bis_sequencer

// ==== sim/bis_seq_asserts.sv ====
// concurrent checks on the burner ignition sequencer ports
module bis_seq_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // field side
  input wire logic lockout_reset,
  input wire logic flame,
  input wire logic low_fire_sw,
  input wire logic ignition_r,
  input wire logic pilot_interrupted_r,
  input wire logic pilot_intermittent_r,
  input wire logic main_valve_r,
  input wire logic blower_r,
  input wire logic fire_low_r,
  // status
  input wire logic lockout_r,
  input wire logic [7:0] fault_code_r,
  input wire logic [10:0] state_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  property p_preign;
    state_r == 11'h002 |-> ignition_r && !pilot_interrupted_r && !pilot_intermittent_r && fire_low_r;
  endproperty
  a_preign: assert property (p_preign) else $error("preignition outputs wrong");
  property p_window;
    state_r == 11'h004 |-> ignition_r && pilot_interrupted_r && pilot_intermittent_r && fire_low_r;
  endproperty
  a_window: assert property (p_window) else $error("window outputs wrong");
  property p_window_end;
    state_r == 11'h004 && !flame ##1 state_r != 11'h004 |-> state_r == 11'h100;
  endproperty
  a_window_end: assert property (p_window_end) else $error("window left without flame");
  property p_low_fire;
    (state_r == 11'h004 || state_r == 11'h010) && !low_fire_sw |=> lockout_r && fault_code_r == 8'h02;
  endproperty
  a_low_fire: assert property (p_low_fire) else $error("low fire opening missed");
  property p_settle;
    state_r == 11'h008 |-> !ignition_r && pilot_interrupted_r && !main_valve_r;
  endproperty
  a_settle: assert property (p_settle) else $error("settle outputs wrong");
  property p_stab;
    state_r == 11'h020 |-> !pilot_interrupted_r && pilot_intermittent_r && main_valve_r;
  endproperty
  a_stab: assert property (p_stab) else $error("stabilization outputs wrong");
  property p_postrun;
    state_r == 11'h080 |-> blower_r && fire_low_r && !main_valve_r && !pilot_intermittent_r;
  endproperty
  a_postrun: assert property (p_postrun) else $error("post-run outputs wrong");
  property p_lock_hold;
    lockout_r && !lockout_reset |=> lockout_r && !ignition_r && !pilot_interrupted_r && !main_valve_r;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lockout not held");
  property p_code_sticky;
    fault_code_r == 8'h6e |=> fault_code_r == 8'h6e && lockout_r;
  endproperty
  a_code_sticky: assert property (p_code_sticky) else $error("jumper lockout cleared");
  c_run: cover property (state_r == 11'h040);
  c_flame_loss: cover property (fault_code_r == 8'h03);
  c_jumper: cover property (fault_code_r == 8'h6e && lockout_reset);
endmodule // bis_seq_asserts

bind bis_sequencer bis_seq_asserts i_bis_seq_asserts (.*);

// ==== sim/bis_field_model.sv ====
// field stand-in: flame amplifier, low-fire and airflow switches
module bis_field_model (
  // sequencer outputs
  input wire logic sys_clk,
  input wire logic ignition_r,
  input wire logic pilot_interrupted_r,
  input wire logic pilot_intermittent_r,
  input wire logic main_valve_r,
  input wire logic blower_r,
  input wire logic fire_low_r,
  // faults commanded by the bench
  input wire logic kill_flame,
  input wire logic open_low_fire,
  input wire logic air_link,
  // returns
  output logic flame,
  output logic low_fire_sw,
  output logic airflow_sw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lit_r = 1'h0;
  wire logic fuel = pilot_interrupted_r || pilot_intermittent_r || main_valve_r;
  // lights only with spark, then holds while any fuel flows; a lost flame stays out
  always @(posedge sys_clk) lit_r <= !kill_flame && fuel && (ignition_r || lit_r);
  assign flame = lit_r;
  assign low_fire_sw = fire_low_r && !open_low_fire;
  assign airflow_sw = blower_r || air_link;
endmodule // bis_field_model

// ==== sim/tb_burner_ignition_sequencer.sv ====
// self-checking bench for the burner ignition sequencer
module tb_burner_ignition_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, call_heat = 1'h0, test_mode = 1'h0;
  logic lockout_reset = 1'h0, react_long = 1'h0, purge_drive_high = 1'h0, purge_timing = 1'h0;
  logic purge_drive_low = 1'h0, purge_done = 1'h0, preign_interlock = 1'h1;
  logic kill_flame = 1'h0, open_low_fire = 1'h0, air_link = 1'h0;
  logic [2:0] jumpers = 3'h7;
  logic purge_hold_r, purge_freeze_r, flame, low_fire_sw, airflow_sw, ignition_r, pilot_interrupted_r;
  logic pilot_intermittent_r, main_valve_r, blower_r, fire_low_r, fire_high_r, fire_modulate_r, lockout_r;
  logic [7:0] fault_code_r;
  logic [10:0] state_r;
  int mismatches = 0;
  int samples_checked = 0;
  // short tick: one second is 100 cycles, latch after 200 cycles of main valve
  bis_sequencer #(.TICK_CYCLES(10), .LATCH_TICKS(20), .POSTRUN_S(2)) i_bis_sequencer (.*);
  bis_field_model i_bis_field_model (.*);
  always #4 sys_clk = ~sys_clk;
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_state(logic [10:0] st, int lim, output int n);
    n = 0;
    while (state_r !== st && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      check(state_r, st);
      tally_and_finish();
    end
  endtask
  // a phase lasts its whole ticks plus two cycles from entry
  task automatic dwell(logic [10:0] st, int secs);
    int n;
    n = 0;
    while (state_r === st && n < 4000) begin
      step(1);
      n++;
    end
    check(n >= secs * 100 - 1 && n <= secs * 100 + 12, 1);
  endtask
  task automatic rst(logic [2:0] j);
    reset_n = 1'h0;
    jumpers = j;
    call_heat = 1'h0;
    kill_flame = 1'h0;
    open_low_fire = 1'h0;
    air_link = 1'h0;
    step(3);
    reset_n = 1'h1;
    step(2);
  endtask
  task automatic go;
    call_heat = 1'h1;
    purge_done = 1'h1;
    step(1);
    purge_done = 1'h0;
  endtask
  task automatic t_purge;
    rst(3'h7);
    call_heat = 1'h1;
    test_mode = 1'h1;
    purge_drive_high = 1'h1;
    step(2);
    check({purge_hold_r, fire_high_r}, 2'h3);
    purge_drive_high = 1'h0;
    purge_timing = 1'h1;
    step(2);
    check({purge_freeze_r, purge_hold_r, fire_high_r}, 3'h5);
    purge_timing = 1'h0;
    purge_drive_low = 1'h1;
    step(2);
    check({purge_hold_r, fire_low_r}, 2'h3);
    test_mode = 1'h0;
    step(2);
    check(purge_hold_r, 1'h0);
    purge_drive_low = 1'h0;
  endtask
  task automatic t_normal;
    int n;
    rst(3'h7);
    go();
    check({ignition_r, pilot_interrupted_r, blower_r, fire_low_r}, 4'hb);
    dwell(11'h002, 3);
    check({ignition_r, pilot_interrupted_r, pilot_intermittent_r}, 3'h7);
    preign_interlock = 1'h0;
    dwell(11'h004, 5);
    check({state_r, ignition_r}, 12'h010);
    test_mode = 1'h1;
    step(700);
    check(state_r, 11'h008);
    test_mode = 1'h0;
    wait_state(11'h010, 600, n);
    check(main_valve_r, 1'h1);
    dwell(11'h010, 5);
    check({state_r, pilot_interrupted_r}, 12'h040);
    dwell(11'h020, 5);
    step(2);
    check({state_r, fire_modulate_r, fire_low_r}, 13'h102);
    test_mode = 1'h1;
    step(2);
    check({fire_modulate_r, fire_low_r}, 2'h1);
    test_mode = 1'h0;
    step(300);
    check(state_r, 11'h040);
    call_heat = 1'h0;
    step(1);
    check({state_r, main_valve_r, pilot_intermittent_r, blower_r, fire_low_r}, 15'h803);
    dwell(11'h080, 2);
    check(state_r, 11'h001);
    preign_interlock = 1'h1;
  endtask
  // runs straight after a full cycle, so the jumpers are latched
  task automatic t_jumper;
    jumpers = 3'h6;
    step(3);
    check({lockout_r, fault_code_r}, 9'h16e);
    lockout_reset = 1'h1;
    step(2);
    lockout_reset = 1'h0;
    check(lockout_r, 1'h1);
  endtask
  task automatic t_short;
    int n;
    rst(3'h0);
    react_long = 1'h1;
    go();
    dwell(11'h002, 3);
    dwell(11'h004, 3);
    dwell(11'h008, 5);
    dwell(11'h010, 3);
    kill_flame = 1'h1;
    wait_state(11'h100, 400, n);
    check(n >= 199 && n <= 215, 1);
    check({fault_code_r, main_valve_r, pilot_intermittent_r}, 10'h00c);
    lockout_reset = 1'h1;
    step(1);
    lockout_reset = 1'h0;
    step(2);
    check(lockout_r, 1'h0);
    react_long = 1'h0;
  endtask
  task automatic t_no_flame;
    int n;
    rst(3'h7);
    kill_flame = 1'h1;
    go();
    wait_state(11'h100, 900, n);
    check({n >= 790, fault_code_r}, 9'h101);
  endtask
  task automatic t_low_fire(logic [10:0] st);
    int n;
    rst(3'h7);
    go();
    wait_state(st, 1500, n);
    step(50);
    open_low_fire = 1'h1;
    step(2);
    check({lockout_r, fault_code_r}, 9'h102);
  endtask
  task automatic t_air;
    rst(3'h3);
    air_link = 1'h1;
    call_heat = 1'h1;
    step(130);
    check({lockout_r, fault_code_r}, 9'h104);
  endtask
  initial begin
    t_purge();
    t_normal();
    t_jumper();
    t_short();
    t_no_flame();
    t_low_fire(11'h004);
    t_low_fire(11'h010);
    t_air();
    tally_and_finish();
  end
endmodule // tb_burner_ignition_sequencer
